/* File: hdl/rox_exec.sv */
// Execution of return-from-interrupt, option-load and return-with-literal instructions
// What this block does
// - The return-from-interrupt opcode loads the program counter from the popped stack top and sets the global interrupt enable, over two cycles, with no status change.
// - The legacy option-load opcode copies the accumulator into the option register within one instruction cycle, with no status change.
// - The option register can also be read and written as an ordinary addressed register.
// - The return-with-literal opcode puts its 8-bit literal in the accumulator and loads the program counter from the popped stack top, ignoring opcode bits 9 and 8, over two cycles, with no status change.
`timescale 1ns/100ps
module rox_exec (
	// Clock and reset
	input  wire logic                            ref_clk_in,
	input  wire logic                            reset_in,
	// Instruction from fetch, sampled in Q1
	input  wire logic [rox_pkg::INSTR_W-1:0]     instr_in,
	// Datapath state
	input  wire logic [rox_pkg::PC_W-1:0]        stack_top_in,
	input  wire logic [rox_pkg::DATA_W-1:0]      accum_in,
	// Addressed option register access
	input  wire logic                            option_wr_in,
	input  wire logic [rox_pkg::DATA_W-1:0]      option_wdata_in,
	output logic      [rox_pkg::DATA_W-1:0]      option_rdata_out,
	// Datapath updates
	output logic                                 pc_load_out,
	output logic      [rox_pkg::PC_W-1:0]        pc_value_out,
	output logic                                 stack_pop_out,
	output logic                                 accum_load_out,
	output logic      [rox_pkg::DATA_W-1:0]      accum_value_out,
	output logic                                 global_interrupt_enable_set_out,
	output logic                                 status_write_out,
	// Fetch control and phase
	output logic                                 refill_out,
	output logic      [3:0]                      phase_out
);
	import rox_pkg::*;

	typedef struct packed {
		rox_op_t                op;
		logic                   refill;
		logic [DATA_W-1:0]      lit;
		logic                   int_en_set;
		logic                   pop;
		logic                   pc_load;
		logic [PC_W-1:0]        pc;
		logic                   w_load;
		logic [DATA_W-1:0]      w;
		logic [DATA_W-1:0]      opt;
	} rox_exec_st_t;

	rox_phase_if ph ();

	rox_phase u_phase (
		.ref_clk_in (ref_clk_in),
		.reset_in   (reset_in),
		.ph         (ph)
	);

	rox_exec_st_t st;
	rox_exec_st_t next_st;

	always_comb begin
		next_st         = st;
		next_st.int_en_set = 1'b0;
		next_st.pop     = 1'b0;
		next_st.pc_load = 1'b0;
		next_st.w_load  = 1'b0;
		// Addressed write to the option register
		if (option_wr_in) begin
			next_st.opt = option_wdata_in;
		end
		case (ph.phase)
			ROX_Q1: begin
				// Decode; the refill cycle runs as a no-operation
				next_st.lit = instr_in[LIT_LSB +: DATA_W];
				if (st.refill) begin
					next_st.op = ROX_NONE;
				end else if (instr_in == OP_RET_INT) begin
					next_st.op = ROX_RET_INT;
				end else if (instr_in == OP_OPTION) begin
					next_st.op = ROX_OPTLD;
				end else if ((instr_in & RET_LIT_MASK) == RET_LIT_PATTERN) begin
					next_st.op = ROX_RET_LIT;
				end else begin
					next_st.op = ROX_NONE;
				end
			end
			ROX_Q2: begin
				// Interrupt enable set lands in Q3
				if (st.op == ROX_RET_INT) begin
					next_st.int_en_set = 1'b1;
				end
			end
			ROX_Q3: begin
				// Pop, accumulator and option writes land in Q4
				if (st.op == ROX_RET_INT || st.op == ROX_RET_LIT) begin
					next_st.pop     = 1'b1;
					next_st.pc_load = 1'b1;
					next_st.pc      = stack_top_in;
				end
				if (st.op == ROX_RET_LIT) begin
					next_st.w_load = 1'b1;
					next_st.w      = st.lit;
				end
				if (st.op == ROX_OPTLD) begin
					next_st.opt = accum_in;
				end
			end
			default: begin
				// End of cycle: a return starts its refill cycle
				next_st.refill = (st.op == ROX_RET_INT || st.op == ROX_RET_LIT);
				next_st.op     = ROX_NONE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			st <= '{
				op:         ROX_NONE,
				refill:     1'b0,
				lit:        DATA_RESET,
				int_en_set: 1'b0,
				pop:        1'b0,
				pc_load:    1'b0,
				pc:         PC_RESET,
				w_load:     1'b0,
				w:          DATA_RESET,
				opt:        OPTION_RESET
			};
		end else begin
			st <= next_st;
		end
	end

	assign option_rdata_out                = st.opt;
	assign pc_load_out                     = st.pc_load;
	assign pc_value_out                    = st.pc;
	assign stack_pop_out                   = st.pop;
	assign accum_load_out                  = st.w_load;
	assign accum_value_out                 = st.w;
	assign global_interrupt_enable_set_out = st.int_en_set;
	assign status_write_out                = 1'b0;
	assign refill_out                      = st.refill;
	assign phase_out                       = ph.phase;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);

	// Return from interrupt
	a_ret_int_enable: assert property (ph.phase == ROX_Q1 && !st.refill && instr_in == OP_RET_INT
		|-> ##2 global_interrupt_enable_set_out ##1 (pc_load_out && stack_pop_out && !accum_load_out))
		else $error("return from interrupt did not set enable then pop");
	a_ret_int_pc: assert property (ph.phase == ROX_Q3 && st.op == ROX_RET_INT
		|=> pc_value_out == $past(stack_top_in))
		else $error("program counter not loaded from stack top");
	a_int_en_phase: assert property (global_interrupt_enable_set_out
		|-> ph.phase == ROX_Q3 && st.op == ROX_RET_INT)
		else $error("interrupt enable set outside Q3 of its return");
	a_pulse_single: assert property (pc_load_out
		|=> !pc_load_out && !stack_pop_out)
		else $error("program counter load longer than one clock");
	a_pc_change: assert property ($changed(pc_value_out)
		|-> pc_load_out)
		else $error("program counter value changed without a load");
	a_status_untouched: assert property (status_write_out == 1'b0)
		else $error("status written");

	// Option register
	a_option_load: assert property (ph.phase == ROX_Q1 && !st.refill && instr_in == OP_OPTION
		|-> ##3 option_rdata_out == $past(accum_in))
		else $error("option register not loaded from accumulator");
	a_option_quiet: assert property (ph.phase == ROX_Q1 && !st.refill && instr_in == OP_OPTION
		|-> ##2 !global_interrupt_enable_set_out ##1 (!pc_load_out && !stack_pop_out && !accum_load_out)
		##1 !refill_out)
		else $error("option load touched return outputs");
	a_option_addr_wr: assert property (option_wr_in && !(ph.phase == ROX_Q3 && st.op == ROX_OPTLD)
		|=> option_rdata_out == $past(option_wdata_in))
		else $error("addressed option write lost");
	a_option_change: assert property ($changed(option_rdata_out)
		|-> $past(option_wr_in) || $past(ph.phase == ROX_Q3 && st.op == ROX_OPTLD))
		else $error("option register changed without a write");

	// Return with literal
	a_ret_lit_decode: assert property (ph.phase == ROX_Q1 && !st.refill
		&& (instr_in & RET_LIT_MASK) == RET_LIT_PATTERN
		|=> st.op == ROX_RET_LIT)
		else $error("literal return not decoded");
	a_ret_lit_accum: assert property (ph.phase == ROX_Q1 && !st.refill
		&& (instr_in & RET_LIT_MASK) == RET_LIT_PATTERN
		|-> ##3 (accum_load_out && pc_load_out && accum_value_out == $past(instr_in[7:0], 3)))
		else $error("literal return did not load accumulator");
	a_ret_lit_pc: assert property (ph.phase == ROX_Q3 && st.op == ROX_RET_LIT
		|=> pc_value_out == $past(stack_top_in))
		else $error("literal return did not load program counter from stack top");
	a_accum_load_phase: assert property (accum_load_out
		|-> ph.phase == ROX_Q4 && stack_pop_out && st.op == ROX_RET_LIT)
		else $error("accumulator load outside Q4 of a literal return");
	a_accum_change: assert property ($changed(accum_value_out)
		|-> accum_load_out)
		else $error("accumulator value changed without a load");
	a_pop_with_load: assert property (stack_pop_out
		|-> pc_load_out && ph.phase == ROX_Q4)
		else $error("pop outside Q4 or without load");

	// Refill cycle
	a_return_refill: assert property (pc_load_out ##1 ph.phase == ROX_Q1
		|-> refill_out [*4] ##1 !refill_out)
		else $error("refill cycle length wrong");
	a_refill_cause: assert property (refill_out && ph.phase == ROX_Q1
		|-> $past(pc_load_out))
		else $error("refill cycle without a return");
	a_refill_no_decode: assert property (refill_out && ph.phase == ROX_Q1
		|=> st.op == ROX_NONE)
		else $error("instruction decoded during refill cycle");
	a_refill_quiet: assert property (refill_out
		|-> !pc_load_out && !stack_pop_out && !accum_load_out && !global_interrupt_enable_set_out)
		else $error("activity during refill cycle");

	c_ret_int: cover property (global_interrupt_enable_set_out ##1 pc_load_out);
	c_ret_lit: cover property (accum_load_out ##1 refill_out);
	c_optld: cover property (ph.phase == ROX_Q3 && st.op == ROX_OPTLD);
	c_back_to_back: cover property (refill_out ##4 !refill_out ##3 pc_load_out);
	c_opt_write_clash: cover property (ph.phase == ROX_Q3 && st.op == ROX_OPTLD && option_wr_in);
endmodule

/* File: hdl/rox_pkg.sv */
// Shared constants and types of the return and option-load execution block
package rox_pkg;
	// Opcode patterns
	localparam logic [13:0] OP_RET_INT      = 14'h0009;
	localparam logic [13:0] OP_OPTION       = 14'h0062;
	localparam logic [13:0] RET_LIT_MASK    = 14'h3c00;
	localparam logic [13:0] RET_LIT_PATTERN = 14'h3400;
	// Widths and field positions
	localparam int INSTR_W = 14;
	localparam int PC_W    = 13;
	localparam int DATA_W  = 8;
	localparam int LIT_LSB = 0;
	// Reset values
	localparam logic [7:0]  OPTION_RESET = 8'hff;
	localparam logic [12:0] PC_RESET     = 13'h0000;
	localparam logic [7:0]  DATA_RESET   = 8'h00;
	// Timing: clocks per instruction cycle, cycles of a return instruction
	localparam int PHASES_PER_CYCLE = 4;
	localparam int RETURN_CYCLES    = 2;
	// Instruction cycle phases
	typedef enum logic [3:0] {
		ROX_Q1 = 4'h1,
		ROX_Q2 = 4'h2,
		ROX_Q3 = 4'h4,
		ROX_Q4 = 4'h8
	} rox_phase_t;
	// Decoded operations
	typedef enum logic [3:0] {
		ROX_NONE   = 4'h1,
		ROX_RET_INT = 4'h2,
		ROX_OPTLD   = 4'h4,
		ROX_RET_LIT = 4'h8
	} rox_op_t;
endpackage

/* File: hdl/rox_phase_if.sv */
// Phase signals shared between the phase generator and the executer
`timescale 1ns/100ps
interface rox_phase_if;
	import rox_pkg::*;
	rox_phase_t phase;
	modport src (output phase);
	modport snk (input phase);
endinterface

/* File: hdl/rox_phase.sv */
// Four-phase instruction cycle generator
`timescale 1ns/100ps
module rox_phase (
	// Clock and reset
	input  wire logic ref_clk_in,
	input  wire logic reset_in,
	// Phase out
	rox_phase_if.src  ph
);
	import rox_pkg::*;

	typedef struct packed {
		rox_phase_t phase;
	} rox_phase_st_t;

	rox_phase_st_t st;
	rox_phase_st_t next_st;

	always_comb begin
		next_st = st;
		case (st.phase)
			ROX_Q1: next_st.phase = ROX_Q2;
			ROX_Q2: next_st.phase = ROX_Q3;
			ROX_Q3: next_st.phase = ROX_Q4;
			default: next_st.phase = ROX_Q1;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			st <= '{phase: ROX_Q1};
		end else begin
			st <= next_st;
		end
	end

	assign ph.phase = st.phase;

	a_phase_rotates: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		st.phase == ROX_Q1 |-> ##4 st.phase == ROX_Q1)
		else $error("phase did not return to Q1 after four clocks");
endmodule

/* File: tb/rox_core_model.sv */
// Behavioural model of the core datapath around the executer
`timescale 1ns/100ps
module rox_core_model (
	// Clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        reset_in,
	// Updates from the executer
	input  wire logic        stack_pop_in,
	input  wire logic        accum_load_in,
	input  wire logic [7:0]  accum_value_in,
	input  wire logic        ie_set_in,
	// Datapath state
	output logic      [12:0] stack_top_out,
	output logic      [7:0]  accum_out,
	output logic             ie_out
);
	logic [2:0] sp;
	assign stack_top_out = {sp, 10'h2a5};
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			sp        <= 3'h7;
			accum_out <= 8'h00;
			ie_out    <= 1'b0;
		end else begin
			if (stack_pop_in) sp <= sp - 3'h1;
			if (accum_load_in) accum_out <= accum_value_in;
			if (ie_set_in) ie_out <= 1'b1;
		end
	end
endmodule

/* File: tb/tb_return_and_option_instr_exec.sv */
// Self-checking bench of the return and option-load executer
`timescale 1ns/100ps
module tb_return_and_option_instr_exec;
	import rox_pkg::*;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic [13:0] instr = 14'h0000;
	logic        opt_wr = 1'b0;
	logic [7:0]  opt_wdata = 8'h00;
	logic [12:0] stack_top, pc_value;
	logic [7:0]  accum, opt_rdata, accum_value;
	logic        pc_load, pop, accum_load, ie_set, status_wr, refill, ie;
	logic [3:0]  phase;
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	always #5 ref_clk = ~ref_clk;
	rox_exec i_dut (.ref_clk_in(ref_clk), .reset_in(reset), .instr_in(instr), .stack_top_in(stack_top),
		.accum_in(accum), .option_wr_in(opt_wr), .option_wdata_in(opt_wdata), .option_rdata_out(opt_rdata),
		.pc_load_out(pc_load), .pc_value_out(pc_value), .stack_pop_out(pop), .accum_load_out(accum_load),
		.accum_value_out(accum_value), .global_interrupt_enable_set_out(ie_set), .status_write_out(status_wr),
		.refill_out(refill), .phase_out(phase));
	rox_core_model i_core (.ref_clk_in(ref_clk), .reset_in(reset), .stack_pop_in(pop), .accum_load_in(accum_load),
		.accum_value_in(accum_value), .ie_set_in(ie_set), .stack_top_out(stack_top), .accum_out(accum), .ie_out(ie));
	task automatic stop_test();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Issue one instruction and follow it through its cycles
	task automatic exec(input logic [13:0] ins, input logic ret, input logic ies, input logic acc, input logic [7:0] k);
		logic [12:0] top;
		do @(negedge ref_clk); while (!(phase === 4'h8 && refill === 1'b0));
		@(posedge ref_clk) instr <= ins;
		@(posedge ref_clk) instr <= 14'h0000;
		@(negedge ref_clk);
		@(negedge ref_clk);
		chk(16'(ie_set), 16'(ies));
		top = stack_top;
		@(negedge ref_clk);
		chk(16'({pc_load, pop, accum_load, status_wr}), 16'({ret, ret, acc, 1'b0}));
		if (ret) chk(16'(pc_value), 16'(top));
		if (acc) chk(16'(accum_value), 16'(k));
		repeat (4) begin
			@(negedge ref_clk);
			chk(16'({refill, pc_load, ie_set}), 16'({ret, 2'b00}));
		end
	endtask
	task automatic t_reset();
		@(negedge ref_clk);
		chk(16'(opt_rdata), 16'(OPTION_RESET));
		chk(16'({pc_load, pop, ie_set, refill}), 16'h0000);
		chk(16'(phase), 16'h0001);
	endtask
	task automatic t_literal();
		exec(14'h3400, 1'b1, 1'b0, 1'b1, 8'h00);
		exec(14'h37ff, 1'b1, 1'b0, 1'b1, 8'hff);
		exec(14'h35a5, 1'b1, 1'b0, 1'b1, 8'ha5);
		chk(16'(accum), 16'h00a5);
	endtask
	task automatic t_interrupt();
		exec(OP_RET_INT, 1'b1, 1'b1, 1'b0, 8'h00);
		chk(16'(ie), 16'h0001);
	endtask
	task automatic t_option();
		@(posedge ref_clk);
		opt_wr    <= 1'b1;
		opt_wdata <= 8'h3c;
		@(posedge ref_clk);
		opt_wr <= 1'b0;
		@(negedge ref_clk);
		chk(16'(opt_rdata), 16'h003c);
		exec(14'h0063, 1'b0, 1'b0, 1'b0, 8'h00);
		chk(16'(opt_rdata), 16'h003c);
		exec(OP_OPTION, 1'b0, 1'b0, 1'b0, 8'h00);
		chk(16'(opt_rdata), 16'h00a5);
	endtask
	// Addressed write on the same edge as the opcode load: the opcode load wins
	task automatic t_clash();
		@(posedge ref_clk);
		opt_wr    <= 1'b1;
		opt_wdata <= 8'h3c;
		@(posedge ref_clk);
		opt_wr <= 1'b0;
		do @(negedge ref_clk); while (!(phase === 4'h8 && refill === 1'b0));
		@(posedge ref_clk) instr <= OP_OPTION;
		@(posedge ref_clk) instr <= 14'h0000;
		@(posedge ref_clk);
		opt_wr    <= 1'b1;
		opt_wdata <= 8'h5a;
		@(posedge ref_clk);
		opt_wr <= 1'b0;
		@(negedge ref_clk);
		chk(16'(opt_rdata), 16'h00a5);
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			stop_test();
		end
	end
	initial begin
		t_reset();
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		t_literal();
		t_interrupt();
		t_option();
		t_clash();
		stop_test();
	end
endmodule
